// ### design/ifeb_flag_word.sv
`default_nettype none
// One flag word: per-bit sticky latch with software write access
module ifeb_flag_word #(
   parameter logic [15:0] IMPL_MASK = 16'h0000
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] req,
   input  wire logic        wr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] flags,
   output logic             new_event
);
   logic [15:0] flag_ff;
   logic [15:0] nxt_flag;

   // Hardware set wins over a software write of zero in the same cycle
   always_comb begin
      nxt_flag = wr ? wdata : flag_ff;
      nxt_flag = (nxt_flag | req) & IMPL_MASK;
   end

   // Sticky flags, cleared at power-on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= ifeb_pkg::RST_WORD;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flags     = flag_ff;
   assign new_event = |(req & IMPL_MASK & ~flag_ff);
endmodule : ifeb_flag_word
`default_nettype wire

// ### design/ifeb_pkg.sv
// Overview of operation
// - Flag word 3 bits 14,6,5,2,1 implemented
// - Flag word 4 bits 13,8,3,2,1 implemented
// - Flag word 5 bits 13..7 implemented
// - Flag word 5 bits 5..1 implemented
// - Flag reads 1 once request occurred
// - Enable 1 passes request, 0 blocks
// - Enable word 0 bits 13..8 implemented
// - Enable word 0 bits 7..5,3..0 implemented
// - Enable word 1 bits 15..9 implemented
// - Enable word 1 bits 7,6,4..0 implemented
// - Unimplemented bits ignore writes, read zero
// - Implemented bits read/write, reset to zero
`default_nettype none
package ifeb_pkg;
   localparam int          WORD_W      = 16;
   localparam int          ADDR_W      = 4;
   // Register offsets (word index on the plain register port)
   localparam logic [3:0]  OFS_FLAG3   = 4'h0;
   localparam logic [3:0]  OFS_FLAG4   = 4'h1;
   localparam logic [3:0]  OFS_FLAG5   = 4'h2;
   localparam logic [3:0]  OFS_EN0     = 4'h3;
   localparam logic [3:0]  OFS_EN1     = 4'h4;
   localparam logic [3:0]  OFS_IRQ_ST  = 4'h5;
   localparam logic [3:0]  OFS_IRQ_MSK = 4'h6;
   // Masks of implemented bits
   localparam logic [15:0] MASK_FLAG3  = 16'h4066;
   localparam logic [15:0] MASK_FLAG4  = 16'h210E;
   localparam logic [15:0] MASK_FLAG5  = 16'h3FBE;
   localparam logic [15:0] MASK_EN0    = 16'h3FEF;
   localparam logic [15:0] MASK_EN1    = 16'hFEDF;
   localparam logic [15:0] RST_WORD    = 16'h0000;
   // Block-interrupt status layout: one bit per flag word
   localparam int          IRQ_W       = 3;
   localparam logic [2:0]  RST_IRQ     = 3'h0;
endpackage : ifeb_pkg
`default_nettype wire

// ### design/ifeb_top.sv
`default_nettype none
// Flag words 3..5 and enable words 0..1 of the interrupt controller.
// Enable word sources keep their flags elsewhere; their flag lines arrive
// as inputs so the pending outputs can be formed here.
module ifeb_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [15:0] REG_RDATA,
   input  wire logic [15:0] REQ_FLAG3,
   input  wire logic [15:0] REQ_FLAG4,
   input  wire logic [15:0] REQ_FLAG5,
   input  wire logic [15:0] FLAG_WORD0,
   input  wire logic [15:0] FLAG_WORD1,
   input  wire logic [15:0] EN_WORD3,
   input  wire logic [15:0] EN_WORD4,
   input  wire logic [15:0] EN_WORD5,
   output logic      [15:0] FLAG3_OUT,
   output logic      [15:0] FLAG4_OUT,
   output logic      [15:0] FLAG5_OUT,
   output logic      [15:0] EN0_OUT,
   output logic      [15:0] EN1_OUT,
   output logic      [15:0] PEND3,
   output logic      [15:0] PEND4,
   output logic      [15:0] PEND5,
   output logic      [15:0] PEND0,
   output logic      [15:0] PEND1,
   output logic             IRQ
);
   logic [15:0] flag3;
   logic [15:0] flag4;
   logic [15:0] flag5;
   logic [2:0]  evt;
   logic [15:0] en0_ff;
   logic [15:0] en1_ff;
   logic [2:0]  irq_st_ff;
   logic [2:0]  irq_msk_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic        wr3;
   logic        wr4;
   logic        wr5;

   assign wr3 = REG_WR && (REG_ADDR == ifeb_pkg::OFS_FLAG3);
   assign wr4 = REG_WR && (REG_ADDR == ifeb_pkg::OFS_FLAG4);
   assign wr5 = REG_WR && (REG_ADDR == ifeb_pkg::OFS_FLAG5);

   // Flag word 3: calendar, external 4/3, two-wire 2 master/slave
   ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::MASK_FLAG3)) u_flag3 (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .req       (REQ_FLAG3),
      .wr        (wr3),
      .wdata     (REG_WDATA),
      .flags     (flag3),
      .new_event (evt[0])
   );

   // Flag word 4: charge timer, low voltage, checksum, serial errors
   ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::MASK_FLAG4)) u_flag4 (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .req       (REQ_FLAG4),
      .wr        (wr4),
      .wdata     (REG_WDATA),
      .flags     (flag4),
      .new_event (evt[1])
   );

   // Flag word 5: capture/compare 9, spi3, serial 4 and 3, two-wire 3
   ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::MASK_FLAG5)) u_flag5 (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .req       (REQ_FLAG5),
      .wr        (wr5),
      .wdata     (REG_WDATA),
      .flags     (flag5),
      .new_event (evt[2])
   );

   // Enable word 0; unimplemented positions masked off on write
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en0_ff <= ifeb_pkg::RST_WORD;
      end else if (REG_WR && (REG_ADDR == ifeb_pkg::OFS_EN0)) begin
         en0_ff <= REG_WDATA & ifeb_pkg::MASK_EN0;
      end
   end

   // Enable word 1
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en1_ff <= ifeb_pkg::RST_WORD;
      end else if (REG_WR && (REG_ADDR == ifeb_pkg::OFS_EN1)) begin
         en1_ff <= REG_WDATA & ifeb_pkg::MASK_EN1;
      end
   end

   // Block event status: set on a new flag, write one to clear; set wins
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_st_ff <= ifeb_pkg::RST_IRQ;
      end else if (REG_WR && (REG_ADDR == ifeb_pkg::OFS_IRQ_ST)) begin
         irq_st_ff <= (irq_st_ff & ~REG_WDATA[2:0]) | evt;
      end else begin
         irq_st_ff <= irq_st_ff | evt;
      end
   end

   // Event mask
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_msk_ff <= ifeb_pkg::RST_IRQ;
      end else if (REG_WR && (REG_ADDR == ifeb_pkg::OFS_IRQ_MSK)) begin
         irq_msk_ff <= REG_WDATA[2:0];
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      unique case (REG_ADDR)
         ifeb_pkg::OFS_FLAG3:   nxt_rdata = flag3;
         ifeb_pkg::OFS_FLAG4:   nxt_rdata = flag4;
         ifeb_pkg::OFS_FLAG5:   nxt_rdata = flag5;
         ifeb_pkg::OFS_EN0:     nxt_rdata = en0_ff;
         ifeb_pkg::OFS_EN1:     nxt_rdata = en1_ff;
         ifeb_pkg::OFS_IRQ_ST:  nxt_rdata = {13'h0000, irq_st_ff};
         ifeb_pkg::OFS_IRQ_MSK: nxt_rdata = {13'h0000, irq_msk_ff};
         default:               nxt_rdata = ifeb_pkg::RST_WORD;
      endcase
   end

   // Read data held only in the cycle after the strobe
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= ifeb_pkg::RST_WORD;
      end else if (REG_RD) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= ifeb_pkg::RST_WORD;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign FLAG3_OUT = flag3;
   assign FLAG4_OUT = flag4;
   assign FLAG5_OUT = flag5;
   assign EN0_OUT   = en0_ff;
   assign EN1_OUT   = en1_ff;

   // Pending request per source: flag gated by enable
   assign PEND3 = flag3 & EN_WORD3;
   assign PEND4 = flag4 & EN_WORD4;
   assign PEND5 = flag5 & EN_WORD5;
   assign PEND0 = FLAG_WORD0 & en0_ff;
   assign PEND1 = FLAG_WORD1 & en1_ff;

   assign IRQ = |(irq_st_ff & irq_msk_ff);
endmodule : ifeb_top
`default_nettype wire

// ### verif/ifeb_chk_assertions.sv
`default_nettype none
// Watches register access, flag latching and pending outputs
module ifeb_chk (
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic [3:0]  REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic [15:0] REQ_FLAG3,
   input wire logic [15:0] REQ_FLAG5,
   input wire logic [15:0] EN_WORD3,
   input wire logic [15:0] FLAG3_OUT,
   input wire logic [15:0] FLAG4_OUT,
   input wire logic [15:0] FLAG5_OUT,
   input wire logic [15:0] EN0_OUT,
   input wire logic [15:0] EN1_OUT,
   input wire logic [15:0] PEND3
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Requests latch at the next edge
   a_flag3_set: assert property (|REQ_FLAG3 |=>
      (FLAG3_OUT & $past(REQ_FLAG3)) == ($past(REQ_FLAG3) & 16'h4066)) else $error("flag3");
   // Without cause a flag of word 3 never moves
   a_flag_hold: assert property (!REG_WR && REQ_FLAG3 == 16'h0000 |=>
      $stable(FLAG3_OUT)) else $error("flag hold");
   // A request beats a software write of zero
   a_flag5_wr: assert property (REG_WR && REG_ADDR == 4'h2 |=>
      FLAG5_OUT == (($past(REG_WDATA) | $past(REQ_FLAG5)) & 16'h3FBE)) else $error("flag5");
   a_en0_wr: assert property (REG_WR && REG_ADDR == 4'h3 |=>
      EN0_OUT == ($past(REG_WDATA) & 16'h3FEF)) else $error("en0");
   a_en1_wr: assert property (REG_WR && REG_ADDR == 4'h4 |=>
      EN1_OUT == ($past(REG_WDATA) & 16'hFEDF)) else $error("en1");
   a_unimpl_zero: assert property (((FLAG3_OUT & ~16'h4066) | (FLAG5_OUT & ~16'h3FBE)
      | (FLAG4_OUT & ~16'h210E) | (EN0_OUT & ~16'h3FEF) | (EN1_OUT & ~16'hFEDF)) == 16'h0000)
      else $error("unimpl");
   a_pend_and: assert property (PEND3 == (FLAG3_OUT & EN_WORD3)) else $error("pend");
   a_read_data: assert property (REG_RD && REG_ADDR == 4'h4 |=>
      REG_RDATA == $past(EN1_OUT)) else $error("rdata");
   cover property (|PEND3);
   cover property (REG_WR && REG_ADDR == 4'h2);
   cover property (REG_RD && REG_ADDR == 4'h4);
endmodule : ifeb_chk
bind ifeb_top ifeb_chk u_chk (.*);
`default_nettype wire

// ### verif/ifeb_src_model.sv
`default_nettype none
// Peripheral sources: each event is a one-cycle request strobe
module ifeb_src_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [1:0]  sel,
   input  wire logic [15:0] bits,
   output logic      [15:0] req3,
   output logic      [15:0] req4,
   output logic      [15:0] req5
);
   // Strobes drop after one cycle so latching is what keeps the event
   // Lines settle to zero at the first edge, while the block is still held in reset
   // External request bits stand for inputs already routed to a remappable pin
   always_ff @(posedge clk) begin
      req3 <= (go && sel == 2'h0) ? bits : 16'h0000;
      req4 <= (go && sel == 2'h1) ? bits : 16'h0000;
      req5 <= (go && sel == 2'h2) ? bits : 16'h0000;
   end
endmodule : ifeb_src_model
`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, go = 1'b0, IRQ;
   logic [3:0] REG_ADDR = 4'h0;
   logic [1:0] sel = 2'h0;
   logic [15:0] REG_WDATA = 16'h0000, bits = 16'h0000, FLAG_WORD0 = 16'h0000;
   logic [15:0] EN_WORD3 = 16'h0000, REQ_FLAG3, REQ_FLAG4, REQ_FLAG5, REG_RDATA;
   logic [15:0] FLAG3_OUT, FLAG4_OUT, FLAG5_OUT, EN0_OUT, EN1_OUT, PEND0, PEND1, PEND3, PEND4, PEND5;
   int num_errors = 0;
   int tests_run = 0;
   // Implemented-bit layouts of the five words
   logic [15:0] msk [5] = '{16'h4066, 16'h210E, 16'h3FBE, 16'h3FEF, 16'hFEDF};
   always #12.5 SYS_CLK = ~SYS_CLK;
   ifeb_top DUT (.*, .FLAG_WORD1(FLAG_WORD0), .EN_WORD4(EN_WORD3), .EN_WORD5(EN_WORD3));
   ifeb_src_model PEER (.clk(SYS_CLK), .go(go), .sel(sel), .bits(bits), .req3(REQ_FLAG3),
      .req4(REQ_FLAG4), .req5(REQ_FLAG5));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Strobes drop a cycle before the next request so no signal is driven twice in a step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
      @(posedge SYS_CLK);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk("read data", REG_RDATA, exp);
      @(posedge SYS_CLK);
   endtask : rd
   task automatic fire(input logic [1:0] s, input logic [15:0] b);
      go <= 1'b1;
      sel <= s;
      bits <= b;
      @(posedge SYS_CLK);
      go <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
   endtask : fire
   // Reset values, then full and empty writes on the five flag and enable words, and a full write to an unmapped one
   task automatic t_access();
      for (int i = 0; i < 5; i++) rd(4'(i), 16'h0000);
      for (int i = 0; i < 5; i++) begin
         wr(4'(i), 16'hFFFF);
         rd(4'(i), msk[i]);
         wr(4'(i), 16'h0000);
         rd(4'(i), 16'h0000);
      end
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
   endtask : t_access
   // Every request line into each flag word, then pending and clearing
   task automatic t_events();
      EN_WORD3 <= 16'h00FF;
      for (int i = 0; i < 3; i++) begin
         fire(2'(i), 16'hFFFF);
         rd(4'(i), msk[i]);
      end
      #1 chk("pend3", PEND3, msk[0] & 16'h00FF);
      chk("pend4", PEND4, msk[1] & 16'h00FF);
      chk("pend5", PEND5, msk[2] & 16'h00FF);
      chk("flag4", FLAG4_OUT, msk[1]);
      @(posedge SYS_CLK);
      for (int i = 0; i < 3; i++) wr(4'(i), 16'h0000);
      #1 chk("flag5", FLAG5_OUT, 16'h0000);
      @(posedge SYS_CLK);
   endtask : t_events
   // Enables gate the outside flags
   task automatic t_enable();
      FLAG_WORD0 <= 16'hAAAA;
      wr(4'h3, 16'hFFFF);
      wr(4'h4, 16'hFFFF);
      #1 chk("pend0", PEND0, 16'hAAAA & msk[3]);
      chk("pend1", PEND1, 16'hAAAA & msk[4]);
      @(posedge SYS_CLK);
      wr(4'h3, 16'h0000);
      #1 chk("pend0 off", PEND0, 16'h0000);
      @(posedge SYS_CLK);
   endtask : t_enable
   // Event status raises, masks and clears the interrupt line
   // Events left from t_events are cleared first so only this event counts
   task automatic t_irq();
      wr(4'h5, 16'h0007);
      wr(4'h6, 16'h0001);
      #1 chk("irq idle", {15'h0000, IRQ}, 16'h0000);
      @(posedge SYS_CLK);
      fire(2'h0, 16'h4000);
      rd(4'h5, 16'h0001);
      #1 chk("irq", {15'h0000, IRQ}, 16'h0001);
      @(posedge SYS_CLK);
      wr(4'h6, 16'h0000);
      #1 chk("irq masked", {15'h0000, IRQ}, 16'h0000);
      @(posedge SYS_CLK);
      wr(4'h6, 16'h0001);
      wr(4'h5, 16'h0001);
      #1 chk("irq cleared", {15'h0000, IRQ}, 16'h0000);
      @(posedge SYS_CLK);
   endtask : t_irq
   task automatic close_out();
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (20) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      @(posedge SYS_CLK);
      t_access();
      t_events();
      t_enable();
      t_irq();
      close_out();
   end
   // Whole run needs some 125 cycles
   initial begin
      repeat (3000) @(posedge SYS_CLK);
      num_errors++;
      close_out();
   end
endmodule : tb_top
`default_nettype wire
